// ### src/fss_pkg.sv
// fault summary status package: offsets, bit positions, source bundle
// assumes a 32-bit apb register bus with byte addresses
package fss_pkg;

  localparam int FSS_ADDR_W = 12;
  localparam int FSS_DATA_W = 32;
  localparam int FSS_STAT_W = 16;

  // byte addresses on apb
  localparam logic [11:0] FSS_STATUS_OFS = 12'h080;
  localparam logic [11:0] FSS_CTRL_OFS = 12'h084;

  // status word layout
  localparam int FSS_BUFFER_ERROR_SUMMARY_BIT = 0;
  localparam int FSS_OSC_BIT = 2;
  localparam int FSS_WDG_BIT = 3;
  localparam int FSS_OT_BIT = 4;
  localparam logic [15:0] FSS_STATUS_RST = 16'h0000;

  // control word layout
  localparam int FSS_DIRECT_BIT = 0;

  // flags owned by this register (set by hardware, cleared by software)
  localparam int FSS_N_OWNED = 2;

  typedef struct packed {
    logic [3:0] external_temp_fault;
    logic gp_input2_temp_fault;
    logic gp_input1_temp_fault;
    logic internal_temp_fault_flag;
    logic buffer_overflow_flag;
    logic buffer_underflow_flag;
    logic osc_fault_event;
    logic watchdog_timeout_event;
  } fss_fault_src_t;

  typedef enum logic [0:0] {
    FSS_WR_CLEAR = 1'b0,
    FSS_WR_DIRECT = 1'b1
  } fss_wr_mode_t;

endpackage : fss_pkg

// ### src/fss_fault_status.sv
// fault summary status register with apb slave
// assumes fault sources are synchronous to pclk and held by their owners
// assumes one apb master, no other writer of the status bits
// unmapped offsets answer with an error and drop any write
//
// Function
// R1 - buffer error is overflow OR underflow
// R2 - writes never touch buffer error bit
// R3 - oscillator fault sets oscillator flag
// R4 - write one at bit 2 clears oscillator
// R5 - watchdog timeout sets watchdog flag
// R6 - write one at bit 3 clears watchdog
// R7 - direct write may force flags to one
// R8 - over-temperature is OR of seven sources
// R9 - over-temperature follows sources, writes ignored
// R10 - all bits zero after reset, fixed layout
// R11 - fault condition whenever any bit set
`timescale 1ns/1ns

module fss_fault_status
  import fss_pkg::*;
#(
  parameter int ADDR_W = FSS_ADDR_W
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [FSS_DATA_W-1:0] pwdata,
  output logic pready,
  output logic [FSS_DATA_W-1:0] prdata,
  output logic pslverr,
  input wire fss_fault_src_t fault_src,
  output logic fault_condition
);

  ////////////////////////////////////////////////////////////////////////////
  // decode

  function automatic logic fss_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [11:0] ofs
  );
    fss_hit = (addr == ADDR_W'(ofs));
  endfunction : fss_hit

  logic pready_reg;
  logic pready_next;
  logic [FSS_DATA_W-1:0] prdata_reg;
  logic [FSS_DATA_W-1:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic fault_reg;
  logic fault_next;
  fss_wr_mode_t mode_reg;
  fss_wr_mode_t mode_next;
  logic buffer_error_summary_reg;
  logic buffer_error_summary_next;
  logic ot_reg;
  logic ot_next;
  logic [FSS_N_OWNED-1:0] owned_reg;
  logic [FSS_N_OWNED-1:0] owned_next;

  wire logic access = psel & penable;
  wire logic done = access & pready_reg;
  wire logic hit_status = fss_hit(paddr, FSS_STATUS_OFS);
  wire logic hit_ctrl = fss_hit(paddr, FSS_CTRL_OFS);
  wire logic mapped = hit_status | hit_ctrl;
  wire logic wr_status = done & pwrite & hit_status;
  wire logic wr_ctrl = done & pwrite & hit_ctrl;

  ////////////////////////////////////////////////////////////////////////////
  // bus phase: one wait state keeps every bus output straight from a flop

  typedef enum logic [1:0] {
    FSS_PH_IDLE = 2'b00,
    FSS_PH_SETUP = 2'b01,
    FSS_PH_ANSWER = 2'b10
  } fss_bus_phase_t;

  fss_bus_phase_t phase_reg;
  fss_bus_phase_t phase_next;

  wire logic in_setup = psel & ~penable;

  always_comb
  begin
    phase_next = FSS_PH_IDLE;
    case (phase_reg)
      FSS_PH_IDLE:
      begin
        if (access)
        begin
          phase_next = FSS_PH_ANSWER;
        end
        else if (in_setup)
        begin
          phase_next = FSS_PH_SETUP;
        end
      end
      FSS_PH_SETUP:
      begin
        if (access)
        begin
          phase_next = FSS_PH_ANSWER;
        end
        else if (in_setup)
        begin
          phase_next = FSS_PH_SETUP;
        end
      end
      FSS_PH_ANSWER:
      begin
        // a new setup may follow the answer at once
        if (in_setup)
        begin
          phase_next = FSS_PH_SETUP;
        end
      end
      default:
      begin
        phase_next = FSS_PH_IDLE;
      end
    endcase
  end

  // a skipped setup cycle is tolerated: any access gets its answer
  wire logic answer_next = (phase_next == FSS_PH_ANSWER);

  assign pready_next = answer_next;
  assign pslverr_next = answer_next & ~mapped;

  ////////////////////////////////////////////////////////////////////////////
  // owned flags: hardware set beats any clearing write

  wire logic [FSS_N_OWNED-1:0] owned_evt = {
    fault_src.watchdog_timeout_event,
    fault_src.osc_fault_event
  };

  genvar gi;
  generate
    for (gi = 0; gi < FSS_N_OWNED; gi++)
    begin : g_owned
      localparam int POS = (gi == 0) ? FSS_OSC_BIT : FSS_WDG_BIT;
      wire logic wbit = pwdata[POS];
      wire logic direct = (mode_reg == FSS_WR_DIRECT);
      wire logic kept = owned_reg[gi] & ~wbit; // R4 R6
      wire logic after_wr = direct ? wbit : kept; // R7
      wire logic hw_set = owned_evt[gi]; // R3 R5
      wire logic held = wr_status ? after_wr : owned_reg[gi];
      // set wins over a clearing write in the same cycle
      assign owned_next[gi] = hw_set | held;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // summary bits: pure ORs, no write path at all

  wire logic [1:0] buf_src = {
    fault_src.buffer_overflow_flag,
    fault_src.buffer_underflow_flag
  };
  wire logic [6:0] temp_src = {
    fault_src.external_temp_fault,
    fault_src.gp_input2_temp_fault,
    fault_src.gp_input1_temp_fault,
    fault_src.internal_temp_fault_flag
  };

  assign buffer_error_summary_next = |buf_src; // R1 R2
  assign ot_next = |temp_src; // R8 R9

  // direct mode is one-shot: armed by control, spent by next status write
  wire fss_wr_mode_t mode_wr = fss_wr_mode_t'(pwdata[FSS_DIRECT_BIT]);
  wire fss_wr_mode_t mode_hold = wr_status ? FSS_WR_CLEAR : mode_reg;

  assign mode_next = wr_ctrl ? mode_wr : mode_hold; // R7

  ////////////////////////////////////////////////////////////////////////////
  // status word and read mux

  function automatic logic [FSS_STAT_W-1:0] fss_pack(
    input logic buffer_error_summary,
    input logic osc,
    input logic wdg,
    input logic ot
  );
    logic [FSS_STAT_W-1:0] w;
    w = FSS_STATUS_RST;
    w[FSS_BUFFER_ERROR_SUMMARY_BIT] = buffer_error_summary;
    w[FSS_OSC_BIT] = osc;
    w[FSS_WDG_BIT] = wdg;
    w[FSS_OT_BIT] = ot;
    fss_pack = w;
  endfunction : fss_pack

  wire logic [FSS_STAT_W-1:0] status_now =
    fss_pack(buffer_error_summary_reg, owned_reg[0], owned_reg[1], ot_reg); // R10
  wire logic [FSS_STAT_W-1:0] status_upd =
    fss_pack(buffer_error_summary_next, owned_next[0], owned_next[1], ot_next);
  wire logic [FSS_DATA_W-1:0] ctrl_word =
    FSS_DATA_W'(mode_reg == FSS_WR_DIRECT) << FSS_DIRECT_BIT;

  ////////////////////////////////////////////////////////////////////////////
  // read path

  wire logic rd_answer = pready_next & ~pwrite;
  wire logic [FSS_DATA_W-1:0] status_word = FSS_DATA_W'(status_now);
  wire logic [FSS_DATA_W-1:0] rd_word = hit_status ? status_word
    : hit_ctrl ? ctrl_word : '0;

  // idle lines stay zero so stale status never lingers on the bus
  assign prdata_next = rd_answer ? rd_word : '0;

  // registered so the flag lines up with the status bits it summarises
  assign fault_next = |status_upd; // R11

  ////////////////////////////////////////////////////////////////////////////
  // bus flops

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_reg <= FSS_PH_IDLE;
    end
    else
    begin
      phase_reg <= phase_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= pready_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= '0;
    end
    else
    begin
      prdata_reg <= prdata_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pslverr_reg <= pslverr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag flops: set by hardware, cleared by software

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      owned_reg <= '0; // R10
    end
    else
    begin
      owned_reg <= owned_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg <= FSS_WR_CLEAR;
    end
    else
    begin
      mode_reg <= mode_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // summary flops: one edge behind their sources

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      buffer_error_summary_reg <= 1'b0; // R10
    end
    else
    begin
      buffer_error_summary_reg <= buffer_error_summary_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ot_reg <= 1'b0; // R10
    end
    else
    begin
      ot_reg <= ot_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault_reg <= 1'b0;
    end
    else
    begin
      fault_reg <= fault_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops

  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign fault_condition = fault_reg;

endmodule : fss_fault_status

// ### test/fss_chk_sva.sv
// checker on the status register apb and fault ports
// assumes the pkg offsets and one wait state per access
`timescale 1ns/1ns
module fss_chk_sva
  import fss_pkg::*;
#(parameter int ADDR_W = FSS_ADDR_W)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic [FSS_DATA_W-1:0] prdata,
  input wire logic pslverr,
  input wire fss_fault_src_t fault_src,
  input wire logic fault_condition
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire hit = paddr == FSS_STATUS_OFS || paddr == FSS_CTRL_OFS;
  wire rd = pready && !pwrite && paddr == FSS_STATUS_OFS;
  a_ready_late: assert property ($rose(penable) && psel |=> pready)
    else $error("ready late");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_map: assert property (pready |-> pslverr == !hit)
    else $error("slverr wrong");
  a_read_zero: assert property (rd |-> !prdata[1] && prdata[31:5] == 0)
    else $error("spare bits set");
  a_buf_cond: assert property (fault_src[3:2] != 0 |=> fault_condition)
    else $error("buffer lost");
  a_temp_cond: assert property (fault_src[10:4] != 0 |=> fault_condition)
    else $error("temp lost");
  a_osc_cond: assert property (fault_src[1] |=> fault_condition)
    else $error("osc lost");
  a_wdg_cond: assert property (fault_src[0] |=> fault_condition)
    else $error("wdg lost");
  cover property (rd && prdata[4]);
  cover property (rd && prdata[3:2] == 2'b11);
  cover property (pready && pslverr);
endmodule : fss_chk_sva
bind fss_fault_status fss_chk_sva #(.ADDR_W(ADDR_W)) u_chk (.*);

// ### test/fss_tb.sv
// bench for the fault summary status register
// drives apb and the fault sources itself
`timescale 1ns/1ns
`define CK(n, e, g) check_count++; if ((g) !== (e)) begin fails++; \
  $display("Error %s exp %h got %h", n, e, g); end
module tb
  import fss_pkg::*;
;
  localparam logic [11:0] st = FSS_STATUS_OFS;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, fault_condition, er;
  fss_fault_src_t src = '0;
  int fails = 0, check_count = 0;
  fss_fault_status dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .fault_src(src), .fault_condition(fault_condition));
  initial forever #50 pclk = ~pclk;
  task print_verdict;
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task rdck(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    `CK("prdata", e, rd)
  endtask : rdck
  task t_reset;
    rdck(st, 32'h0000_0000);
    `CK("fault", 1'b0, fault_condition)
    rdck(12'h010, 32'h0000_0000);
    `CK("slverr", 1'b1, er)
  endtask : t_reset
  // a write of all ones while held must not move summary bits
  task t_summary(input int b, input int s);
    src[b] <= 1;
    apb(1, st, 32'h0000_ffff);
    rdck(st, 32'h0000_0001 << s);
    `CK("fault", 1'b1, fault_condition)
    src[b] <= 0;
    rdck(st, 32'h0000_0000);
    `CK("fault", 1'b0, fault_condition)
  endtask : t_summary
  task t_event(input int b, input int s, input logic [31:0] m);
    @(posedge pclk);
    src[b] <= 1;
    @(posedge pclk);
    src[b] <= 0;
    rdck(st, 32'h0000_0001 << s);
    apb(1, st, 32'h0000_0001 << (5 - s));
    rdck(st, 32'h0000_0001 << s);
    apb(1, st, m);
    rdck(st, 32'h0000_0000);
  endtask : t_event
  task t_direct;
    apb(1, FSS_CTRL_OFS, 32'h0000_0001);
    apb(1, st, 32'h0000_000c);
    rdck(st, 32'h0000_000c);
    `CK("fault", 1'b1, fault_condition)
    rdck(FSS_CTRL_OFS, 32'h0000_0000);
    apb(1, st, 32'h0000_0004);
    rdck(st, 32'h0000_0008);
    apb(1, st, 32'h0000_ffff);
    rdck(st, 32'h0000_0000);
  endtask : t_direct
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    t_reset;
    for (int i = 2; i < 11; i++) t_summary(i, i < 4 ? 0 : 4);
    t_event(1, 2, 32'h0000_0004);
    t_event(0, 3, 32'h0000_0008);
    t_event(1, 2, 32'h0000_ffff);
    t_event(0, 3, 32'h0000_ffff);
    t_direct;
    print_verdict;
  end
  // run needs a few hundred cycles; this is far beyond
  initial
  begin
    #1000000;
    fails++;
    print_verdict;
  end
endmodule : tb
